// >>> design/area_map.svh
// address map, field positions, resets and timing counts for the area decoder
`ifndef AREA_MAP_SVH
`define AREA_MAP_SVH

`define AREA_COUNT        9
`define AREA_SIZE_MB      64
`define AREA_IDX_LSB      26
`define AREA_IDX_MSB      28
`define UNCACHE_BIT       29
`define AREA8_BASE_TOP    2'h1
`define WIN_TOP_CS        3'h0
`define WIN_TOP_UC        3'h1

`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_REFRESH       12'h008
`define REG_BUS_REQUEST_IN          12'h00C
`define REG_AREA_BASE     12'h040
`define REG_AREA_LAST     12'h060

`define F_WIDTH_LSB       0
`define F_TYPE_LSB        2
`define F_RWAIT_LSB       8
`define F_WWAIT_LSB       12
`define F_IDLE_LSB        16

`define AREA_CFG_RESET    32'h00000000
`define CTRL_RESET        32'h00000000
`define REFRESH_RESET     32'h00000000

`define WIDTH_8           2'h1
`define WIDTH_16          2'h2
`define WIDTH_32          2'h3

`define RELEASE_NS        8
`define RELEASE_CYC       ((`RELEASE_NS + 3) / 4)

`endif

// >>> design/area_pkg.sv
// types shared by the area decoder
package area_pkg;
	typedef enum logic [2:0] {
		MEM_NORMAL   = 3'h0,
		MEM_BYTESEL  = 3'h1,
		MEM_BROM_AS  = 3'h2,
		MEM_BROM_SY  = 3'h3,
		MEM_SDRAM    = 3'h4,
		MEM_MUXED    = 3'h5,
		MEM_MUXBURST = 3'h6,
		MEM_CARD     = 3'h7
	} mem_type_t;

	typedef enum logic [2:0] {
		ARB_OWN     = 3'b001,
		ARB_RELEASE = 3'b010,
		ARB_GRANTED = 3'b100
	} arb_state_t;
endpackage : area_pkg

// >>> design/external_area_decoder.sv
// external area decoder: chip select, cacheability, widths, lanes, arbitration
// Functional notes
// - areas 0-7 span 64 MB each, area eight spans 1 GB
// - areas 0-7 cacheable when A29 low
// - area eight always uncacheable
// - uncached alias slices from 0x20000000 upward
// - synchronous burst ROM only in area 0
// - SDRAM allowed only in areas 2 and 3
// - area 6 and 5 card/muxed type limits
// - width per area: 8, 16, 32
// - straps set area zero width at reset
// - area zero width fixed after reset
// - areas 1-8 start at area 0 width
// - separate read and write wait per area
// - five independent idle-cycle cases
// - refresh burst count 1,2,4,6,8
// - compare match raises interrupt request
// - byte strobes mark written lanes; byte-select type marks read lanes too
// - strobes are data masks for SDRAM
// - card mode selects per byte lane
// - card mode strobes become I/O, mem strobes
// - top strobe is address hold, muxed
// - request released resources, then grant
// - pending refresh shown while released
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "area_map.svh"
module external_area_decoder (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        i_HSEL,
	input  wire logic [31:0] i_HADDR,
	input  wire logic [1:0]  i_HTRANS,
	input  wire logic        i_HWRITE,
	input  wire logic [2:0]  i_HSIZE,
	input  wire logic [31:0] i_HWDATA,
	input  wire logic        i_HREADY,
	output logic      [31:0] o_HRDATA,
	output logic             o_HREADYOUT,
	output logic             o_HRESP,
	input  wire logic        i_CPU_REQ,
	input  wire logic [31:0] i_CPU_ADDR,
	input  wire logic        i_CPU_WRITE,
	input  wire logic [3:0]  i_CPU_LANES,
	input  wire logic        i_REFRESH_TICK,
	input  wire logic        i_WIDTH_STRAP_HI,
	input  wire logic        i_WIDTH_STRAP_LO,
	input  wire logic        i_BUS_REQUEST_IN,
	output logic             o_BUS_GRANT,
	output logic             o_REFRESH_REQUEST_OUT,
	output logic             o_CYCLE_START_N,
	output logic      [8:0]  o_AREA_SELECT_N,
	output logic             o_CARD_HI_SELECT_A,
	output logic             o_CARD_HI_SELECT_B,
	output logic      [3:0]  o_LANE_STROBE,
	output logic             o_CACHEABLE,
	output logic      [1:0]  o_CYCLE_WIDTH,
	output logic      [3:0]  o_CYCLE_WAIT,
	output logic      [2:0]  o_CYCLE_IDLE,
	output logic      [3:0]  o_REFRESH_BURST,
	output logic             o_REFRESH_IRQ
);
	// area configuration words: width, type, read wait, write wait, idle
	logic [31:0] area_cfg_reg [`AREA_COUNT];
	logic [31:0] ctrl_reg;
	logic [31:0] refresh_reg;
	logic [7:0]  refresh_count_reg;
	logic        refresh_irq_reg;
	logic        refresh_pend_reg;
	logic [1:0]  width0_reg;
	logic        strap_done_reg;
	logic [1:0]  strap_hi_sync_reg;
	logic [1:0]  strap_lo_sync_reg;
	logic [1:0]  bus_request_in_sync_reg;
	logic        dp_valid_reg;
	logic        dp_write_reg;
	logic [11:0] dp_addr_reg;
	area_pkg::arb_state_t arb_reg;
	logic [1:0]  release_cnt_reg;
	logic        last_write_reg;
	logic [3:0]  last_area_reg;
	logic        had_cycle_reg;

	// strap and bus request pins come from outside; two flops each
	always_ff @(posedge I_CLK) begin
		strap_hi_sync_reg <= {strap_hi_sync_reg[0], i_WIDTH_STRAP_HI};
		strap_lo_sync_reg <= {strap_lo_sync_reg[0], i_WIDTH_STRAP_LO};
		bus_request_in_sync_reg     <= {bus_request_in_sync_reg[0], i_BUS_REQUEST_IN};
	end

	// decoded strap width; areas 1-8 load it at the same edge as area 0
	logic [1:0]  strap_width;
	always_comb begin
		unique case ({strap_hi_sync_reg[1], strap_lo_sync_reg[1]})
			2'b11:   strap_width = `WIDTH_32;
			2'b10:   strap_width = `WIDTH_16;
			2'b01:   strap_width = `WIDTH_8;
			default: strap_width = `WIDTH_32;
		endcase
	end

	// straps caught once after reset release, never altered after
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			strap_done_reg <= 1'b0;
			width0_reg     <= `WIDTH_32;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			width0_reg     <= strap_width;
		end
	end

	// ahb-lite slave: zero wait states, always OKAY
	wire ahb_go = i_HSEL && i_HREADY && i_HTRANS[1];
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 12'h000;
		end else begin
			dp_valid_reg <= ahb_go;
			dp_write_reg <= i_HWRITE;
			dp_addr_reg  <= i_HADDR[11:0];
		end
	end
	assign o_HREADYOUT = 1'b1;
	assign o_HRESP     = 1'b0;
	wire wr_en = dp_valid_reg && dp_write_reg;
	wire rd_go = ahb_go && !i_HWRITE;

	function automatic logic [31:0] legal_cfg(input logic [3:0] idx,
	                                          input logic [31:0] d);
		logic [31:0] r;
		logic [2:0]  t;
		r = d;
		t = d[`F_TYPE_LSB +: 3];
		unique case (area_pkg::mem_type_t'(t))
			area_pkg::MEM_BROM_SY:  if (idx != 4'h0) t = 3'h0;
			area_pkg::MEM_BROM_AS:
				if (idx != 4'h0 && idx != 4'h4) t = 3'h0;
			area_pkg::MEM_SDRAM:
				if (idx != 4'h2 && idx != 4'h3) t = 3'h0;
			area_pkg::MEM_MUXED:    if (idx != 4'h5) t = 3'h0;
			area_pkg::MEM_MUXBURST: if (idx != 4'h6) t = 3'h0;
			area_pkg::MEM_CARD:
				if (idx != 4'h5 && idx != 4'h6) t = 3'h0;
			default: ;
		endcase
		if (d[1:0] == 2'h0)
			r[1:0] = `WIDTH_32;
		r[`F_TYPE_LSB +: 3] = t;
		return r;
	endfunction : legal_cfg

	genvar g;
	generate
		for (g = 0; g < `AREA_COUNT; g++) begin : g_area
			localparam logic [11:0] OFS = `REG_AREA_BASE + 12'(4 * g);
			always_ff @(posedge I_CLK) begin
				if (!I_RST_N) begin
					area_cfg_reg[g] <= `AREA_CFG_RESET;
				end else if (g != 0 && !strap_done_reg) begin
					area_cfg_reg[g][1:0] <= strap_width;
				end else if (wr_en && dp_addr_reg == OFS) begin
					area_cfg_reg[g] <= legal_cfg(4'(g), i_HWDATA);
				end
			end
		end
	endgenerate

	// area zero width always reads from the strap latch
	function automatic logic [1:0] area_width(input logic [3:0] idx);
		if (idx == 4'h0)
			return width0_reg;
		return area_cfg_reg[idx][1:0];
	endfunction : area_width

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ctrl_reg    <= `CTRL_RESET;
			refresh_reg <= `REFRESH_RESET;
		end else if (wr_en) begin
			if (dp_addr_reg == `REG_CTRL)
				ctrl_reg <= i_HWDATA;
			if (dp_addr_reg == `REG_REFRESH)
				refresh_reg <= i_HWDATA;
		end
	end

	// refresh counter compare; the set wins over a clear in the same cycle
	wire cmp_hit = i_REFRESH_TICK && (refresh_count_reg == refresh_reg[7:0]);
	wire irq_clr = wr_en && dp_addr_reg == `REG_STATUS && i_HWDATA[0];
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			refresh_count_reg <= 8'h00;
			refresh_irq_reg   <= 1'b0;
			refresh_pend_reg  <= 1'b0;
		end else begin
			if (cmp_hit)
				refresh_count_reg <= 8'h00;
			else if (i_REFRESH_TICK)
				refresh_count_reg <= refresh_count_reg + 8'h01;
			if (cmp_hit)
				refresh_irq_reg <= 1'b1;
			else if (irq_clr)
				refresh_irq_reg <= 1'b0;
			if (cmp_hit)
				refresh_pend_reg <= 1'b1;
			else if (arb_reg == area_pkg::ARB_OWN)
				refresh_pend_reg <= 1'b0;
		end
	end
	assign o_REFRESH_IRQ = refresh_irq_reg;

	always_comb begin
		unique case (refresh_reg[10:8])
			3'h0:    o_REFRESH_BURST = 4'h1;
			3'h1:    o_REFRESH_BURST = 4'h2;
			3'h2:    o_REFRESH_BURST = 4'h4;
			3'h3:    o_REFRESH_BURST = 4'h6;
			3'h4:    o_REFRESH_BURST = 4'h8;
			default: o_REFRESH_BURST = 4'h1;
		endcase
	end

	// arbitration: drop the bus for a few cycles before granting
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			arb_reg         <= area_pkg::ARB_OWN;
			release_cnt_reg <= 2'h0;
		end else begin
			unique case (arb_reg)
				area_pkg::ARB_OWN: if (bus_request_in_sync_reg[1]) begin
					arb_reg         <= area_pkg::ARB_RELEASE;
					release_cnt_reg <= 2'(`RELEASE_CYC);
				end
				area_pkg::ARB_RELEASE: begin
					if (release_cnt_reg == 2'h1)
						arb_reg <= area_pkg::ARB_GRANTED;
					release_cnt_reg <= release_cnt_reg - 2'h1;
				end
				area_pkg::ARB_GRANTED: if (!bus_request_in_sync_reg[1])
					arb_reg <= area_pkg::ARB_OWN;
				default: arb_reg <= area_pkg::ARB_OWN;
			endcase
		end
	end
	wire bus_ours = arb_reg == area_pkg::ARB_OWN;
	assign o_BUS_GRANT = arb_reg == area_pkg::ARB_GRANTED;
	assign o_REFRESH_REQUEST_OUT = o_BUS_GRANT && refresh_pend_reg;

	// address decode
	logic       hit;
	logic [3:0] area;
	logic       cacheable;
	always_comb begin
		hit       = 1'b0;
		area      = 4'h0;
		cacheable = 1'b0;
		if (i_CPU_ADDR[31:30] == `AREA8_BASE_TOP) begin
			hit  = 1'b1;
			area = 4'h8;
		end else if (i_CPU_ADDR[31:30] == 2'h0) begin
			hit  = 1'b1;
			area = {1'b0, i_CPU_ADDR[`AREA_IDX_MSB:`AREA_IDX_LSB]};
			cacheable = !i_CPU_ADDR[`UNCACHE_BIT];
		end
	end
	wire go = i_CPU_REQ && hit && bus_ours;

	logic [31:0] cfg;
	area_pkg::mem_type_t mtype;
	always_comb begin
		cfg   = area_cfg_reg[area];
		mtype = area_pkg::mem_type_t'(cfg[`F_TYPE_LSB +: 3]);
	end
	wire card = mtype == area_pkg::MEM_CARD;

	// idle choice: rw same, rw diff, rr same, rr diff, after write
	logic [2:0] idle_sel;
	always_comb begin
		if (last_write_reg)
			idle_sel = 3'h4;
		else if (i_CPU_WRITE)
			idle_sel = (area == last_area_reg) ? 3'h0 : 3'h1;
		else
			idle_sel = (area == last_area_reg) ? 3'h2 : 3'h3;
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			o_CYCLE_START_N    <= 1'b1;
			o_AREA_SELECT_N    <= 9'h1FF;
			o_CARD_HI_SELECT_A <= 1'b0;
			o_CARD_HI_SELECT_B <= 1'b0;
			o_LANE_STROBE      <= 4'h0;
			o_CACHEABLE        <= 1'b0;
			o_CYCLE_WIDTH      <= `WIDTH_32;
			o_CYCLE_WAIT       <= 4'h0;
			o_CYCLE_IDLE       <= 3'h0;
			last_write_reg     <= 1'b0;
			last_area_reg      <= 4'h0;
			had_cycle_reg      <= 1'b0;
		end else begin
			o_CYCLE_START_N    <= !go;
			o_AREA_SELECT_N    <= 9'h1FF;
			o_CARD_HI_SELECT_A <= 1'b0;
			o_CARD_HI_SELECT_B <= 1'b0;
			o_LANE_STROBE      <= 4'h0;
			if (go) begin
				o_AREA_SELECT_N[area] <= card && !i_CPU_LANES[0];
				o_CACHEABLE   <= cacheable;
				o_CYCLE_WIDTH <= area_width(area);
				o_CYCLE_WAIT  <= i_CPU_WRITE ? cfg[`F_WWAIT_LSB +: 4]
				                             : cfg[`F_RWAIT_LSB +: 4];
				o_CYCLE_IDLE  <= had_cycle_reg
					? cfg[`F_IDLE_LSB + 3 * idle_sel +: 3] : 3'h0;
				last_write_reg <= i_CPU_WRITE;
				last_area_reg  <= area;
				had_cycle_reg  <= 1'b1;
				if (card) begin
					o_CARD_HI_SELECT_A <= area == 4'h5 && i_CPU_LANES[1];
					o_CARD_HI_SELECT_B <= area == 4'h6 && i_CPU_LANES[1];
					o_LANE_STROBE <= {ctrl_reg[0] && i_CPU_WRITE,
					                  ctrl_reg[0] && !i_CPU_WRITE,
					                  !ctrl_reg[0] && i_CPU_WRITE,
					                  1'b0};
				end else if (mtype == area_pkg::MEM_SDRAM)
					o_LANE_STROBE <= ~i_CPU_LANES;
				else if (mtype == area_pkg::MEM_MUXED ||
				         mtype == area_pkg::MEM_MUXBURST)
					o_LANE_STROBE <= {1'b1,
					                  i_CPU_LANES[2:0] & {3{i_CPU_WRITE}}};
				else if (mtype == area_pkg::MEM_BYTESEL)
					o_LANE_STROBE <= i_CPU_LANES;
				else
					o_LANE_STROBE <= i_CPU_LANES & {4{i_CPU_WRITE}};
			end
		end
	end

	// register read data
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			o_HRDATA <= 32'h00000000;
		else if (rd_go) begin
			unique case (i_HADDR[11:0])
				`REG_CTRL:    o_HRDATA <= ctrl_reg;
				`REG_STATUS:  o_HRDATA <= {28'h0000000, o_BUS_GRANT,
				                           refresh_pend_reg, 1'b0,
				                           refresh_irq_reg};
				`REG_REFRESH: o_HRDATA <= {refresh_reg[31:16],
				                           refresh_count_reg,
				                           refresh_reg[7:0]};
				default: begin
					o_HRDATA <= 32'h00000000;
					for (int k = 0; k < `AREA_COUNT; k++)
						if (i_HADDR[11:0] == `REG_AREA_BASE + 12'(4 * k))
							o_HRDATA <= {area_cfg_reg[k][31:2],
							             area_width(4'(k))};
				end
			endcase
		end
	end

	chk_no_sel_outside: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		i_CPU_REQ && !hit |=> o_AREA_SELECT_N == 9'h1FF && o_CYCLE_START_N)
		else $error("select asserted outside windows");
	chk_area8_uncached: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		go && area == 4'h8 |=> !o_CACHEABLE)
		else $error("area eight cacheable");
	chk_a29_cache: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		go && area != 4'h8 |=> o_CACHEABLE == !$past(i_CPU_ADDR[29]))
		else $error("cacheability does not follow A29");
	chk_area_index: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		go && area != 4'h8 && !card |=>
		!o_AREA_SELECT_N[$past(i_CPU_ADDR[28:26])])
		else $error("wrong area select");
	chk_width0_fixed: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		strap_done_reg |=> $stable(width0_reg))
		else $error("area zero width changed");
	chk_grant_after_rel: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$rose(o_BUS_GRANT) |-> $past(arb_reg) == area_pkg::ARB_RELEASE)
		else $error("grant without release");
	chk_no_cycle_grant: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		o_BUS_GRANT |=> o_CYCLE_START_N)
		else $error("cycle while bus granted");
	chk_irq_on_match: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		cmp_hit |=> o_REFRESH_IRQ)
		else $error("compare match without irq");
	chk_refresh_request_out: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		o_REFRESH_REQUEST_OUT |-> o_BUS_GRANT ##0 refresh_pend_reg)
		else $error("refresh request outside release");
	chk_sdram_only23: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		area_cfg_reg[1][4:2] != 3'h4 && area_cfg_reg[7][4:2] != 3'h4)
		else $error("sdram type in wrong area");
	cov_grant: cover property (@(posedge I_CLK) $rose(o_BUS_GRANT));
	cov_card: cover property (@(posedge I_CLK) go && card);
	cov_irq: cover property (@(posedge I_CLK) $rose(o_REFRESH_IRQ));
endmodule : external_area_decoder

// >>> dv/ext_partner.sv
// far-side model: external bus master watching grant and cycle start
`timescale 1ns/1ps
module ext_partner (
	input  wire logic       i_clk,
	input  wire logic       i_want,
	input  wire logic       i_grant,
	input  wire logic       i_start_n,
	output logic            o_req,
	output logic      [7:0] o_starts
);
	initial o_req = 1'b0;
	initial o_starts = 8'h00;
	// request stays up for as long as the bus is wanted, granted or not
	always @(posedge i_clk) begin
		o_req <= i_want;
	end
	// a cycle start while we own the bus would be a collision
	always @(posedge i_clk) begin
		if (i_grant && !i_start_n)
			o_starts <= o_starts + 8'h01;
	end
endmodule : ext_partner

// >>> dv/external_area_decoder_tb.sv
// self-checking bench for the external area decoder
`timescale 1ns/1ps
module external_area_decoder_tb;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic        creq;
	logic [31:0] caddr;
	logic        cwr;
	logic [3:0]  clanes;
	logic        tick;
	logic        shi;
	logic        slo;
	logic        want;
	wire         bus_request_in;
	wire  [7:0]  starts;
	wire  [31:0] hrdata;
	wire         hready;
	wire         grant;
	wire         rref;
	wire         start_n;
	wire  [8:0]  sel_n;
	wire         chs_a;
	wire         chs_b;
	wire  [3:0]  strobe;
	wire         cach;
	wire  [1:0]  width;
	wire  [3:0]  waitc;
	wire  [2:0]  idle;
	wire  [3:0]  burst;
	wire         irq;
	int          errors;
	int          n_checks;

	external_area_decoder uut (.I_CLK(clk), .I_RST_N(rst_n),
		.i_HSEL(hsel), .i_HADDR(haddr), .i_HTRANS(htrans),
		.i_HWRITE(hwrite), .i_HSIZE(3'h2), .i_HWDATA(hwdata),
		.i_HREADY(1'b1), .o_HRDATA(hrdata), .o_HREADYOUT(hready),
		.o_HRESP(), .i_CPU_REQ(creq), .i_CPU_ADDR(caddr),
		.i_CPU_WRITE(cwr), .i_CPU_LANES(clanes),
		.i_REFRESH_TICK(tick), .i_WIDTH_STRAP_HI(shi),
		.i_WIDTH_STRAP_LO(slo), .i_BUS_REQUEST_IN(bus_request_in),
		.o_BUS_GRANT(grant), .o_REFRESH_REQUEST_OUT(rref),
		.o_CYCLE_START_N(start_n), .o_AREA_SELECT_N(sel_n),
		.o_CARD_HI_SELECT_A(chs_a), .o_CARD_HI_SELECT_B(chs_b),
		.o_LANE_STROBE(strobe), .o_CACHEABLE(cach),
		.o_CYCLE_WIDTH(width), .o_CYCLE_WAIT(waitc),
		.o_CYCLE_IDLE(idle), .o_REFRESH_BURST(burst),
		.o_REFRESH_IRQ(irq));

	ext_partner far (.i_clk(clk), .i_want(want), .i_grant(grant),
		.i_start_n(start_n), .o_req(bus_request_in), .o_starts(starts));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic lim(input int n, input int max);
		if (n >= max) begin
			errors++;
			$display("unexpected %0t wait ran out", $time);
			end_of_test();
		end
	endtask : lim

	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		lim(n, 64);
	endtask : hwait

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b1;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		#1;
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b0;
		hwait();
		htrans <= 2'h0;
		hwait();
		d = hrdata;
	endtask : rd

	// outputs of the access stand in the cycle after the request edge
	task automatic acc(input logic [31:0] a, input logic w,
		input logic [3:0] l);
		@(posedge clk);
		creq <= 1'b1;
		caddr <= a;
		cwr <= w;
		clanes <= l;
		@(posedge clk);
		creq <= 1'b0;
		#1;
	endtask : acc

	task automatic rst(input logic h, input logic l);
		@(posedge clk);
		shi <= h;
		slo <= l;
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : rst

	task automatic t_width();
		logic [31:0] d;
		for (int w = 1; w <= 3; w++) begin
			rst(w != 1, w != 2);
			acc(32'h00000000, 1'b0, 4'hF);
			chk(width, w);
			acc(32'h44000000, 1'b0, 4'hF);
			chk(width, w);
			rd(32'h00000040, d);
			chk(d[1:0], w);
		end
		wr(32'h00000040, 32'h00000001);
		acc(32'h00000000, 1'b0, 4'hF);
		chk(width, 2'h3);
		for (int w = 0; w <= 3; w++) begin
			wr(32'h00000044, w);
			acc(32'h04000000, 1'b0, 4'hF);
			chk(width, (w == 0) ? 3 : w);
		end
	endtask : t_width

	// every slice at one end, low end for even and top end for odd, cached and uncached, then outside
	task automatic t_decode();
		logic [31:0] a;
		logic [8:0]  es;
		int          ar;
		for (int i = 0; i < 17; i++) begin
			a = (i < 16) ? i * 32'h04000000 : 32'h40000000;
			a = a + (i[0] ? 32'h03FFFFFC : 32'h00000000);
			ar = (i < 16) ? i % 8 : 8;
			es = ~(9'h001 << ar);
			acc(a, 1'b0, 4'hF);
			chk(start_n, 1'b0);
			chk(sel_n, es);
			chk(cach, i < 8);
		end
		acc(32'h80000000, 1'b1, 4'hF);
		chk({start_n, sel_n}, 10'h3FF);
	endtask : t_decode

	task automatic t_types();
		wr(32'h00000044, 32'h00000010);
		wr(32'h00000048, 32'h00000010);
		wr(32'h00000050, 32'h00000010);
		wr(32'h00000054, 32'h00000014);
		wr(32'h00000058, 32'h00000014);
		acc(32'h04000000, 1'b1, 4'h5);
		chk(strobe, 4'h5);
		acc(32'h04000000, 1'b0, 4'hF);
		chk(strobe, 4'h0);
		acc(32'h08000000, 1'b1, 4'h3);
		chk(strobe, 4'hC);
		acc(32'h10000000, 1'b1, 4'h3);
		chk(strobe, 4'h3);
		acc(32'h14000000, 1'b0, 4'hF);
		chk(strobe[3], 1'b1);
		acc(32'h18000000, 1'b0, 4'hF);
		chk(strobe[3], 1'b0);
		wr(32'h00000054, 32'h0000001C);
		wr(32'h00000058, 32'h0000001C);
		acc(32'h14000000, 1'b1, 4'h3);
		chk({chs_a, sel_n[5]}, 2'h2);
		acc(32'h18000000, 1'b1, 4'h3);
		chk({chs_b, sel_n[6]}, 2'h2);
		chk(strobe[1], 1'b1);
		wr(32'h00000000, 32'h00000001);
		acc(32'h18000000, 1'b1, 4'h3);
		chk(strobe[3:2], 2'h2);
		acc(32'h18000000, 1'b0, 4'h3);
		chk(strobe[3:2], 2'h1);
		wr(32'h00000000, 32'h00000000);
	endtask : t_types

	// idle field k holds k+1, so each back-to-back case shows its own value
	task automatic t_wait();
		logic [31:0] v;
		v = 32'h00009500;
		for (int k = 0; k < 5; k++)
			v = v | ((k + 1) << (16 + 3 * k));
		wr(32'h0000004C, v);
		wr(32'h00000050, v);
		acc(32'h0C000000, 1'b0, 4'hF);
		acc(32'h0C000000, 1'b1, 4'hF);
		chk({waitc, 1'b0, idle}, 8'h91);
		acc(32'h0C000000, 1'b0, 4'hF);
		chk({waitc, 1'b0, idle}, 8'h55);
		acc(32'h10000000, 1'b1, 4'hF);
		chk(idle, 3'h2);
		acc(32'h10000000, 1'b0, 4'hF);
		acc(32'h10000000, 1'b0, 4'hF);
		chk(idle, 3'h3);
		acc(32'h0C000000, 1'b0, 4'hF);
		chk(idle, 3'h4);
	endtask : t_wait

	task automatic pulse();
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	endtask : pulse

	task automatic t_refresh();
		logic [31:0] d;
		int          n;
		for (int c = 0; c < 5; c++) begin
			wr(32'h00000008, c << 8);
			chk(burst, (c == 0) ? 1 : 2 * c);
		end
		wr(32'h00000008, 32'h00000003);
		pulse();
		pulse();
		chk(irq, 1'b0);
		pulse();
		pulse();
		n = 0;
		while (irq !== 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		lim(n, 8);
		pulse();
		rd(32'h00000004, d);
		chk(d[0], 1'b1);
		wr(32'h00000004, 32'h00000001);
		@(posedge clk);
		chk(irq, 1'b0);
		rd(32'h000000F0, d);
		chk(d, 32'h00000000);
	endtask : t_refresh

	task automatic t_arb();
		int n;
		chk(rref, 1'b0);
		@(posedge clk);
		want <= 1'b1;
		n = 0;
		while (grant !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		lim(n, 20);
		chk(n >= 3, 1'b1);
		acc(32'h0C000000, 1'b1, 4'hF);
		chk({start_n, sel_n, starts}, 18'h3FF00);
		repeat (3) pulse();
		@(posedge clk);
		#1;
		chk(rref, 1'b1);
		want <= 1'b0;
		n = 0;
		while (grant !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		lim(n, 20);
	endtask : t_arb

	initial begin
		errors = 0;
		n_checks = 0;
		rst_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{creq, caddr, cwr, clanes, tick, want} = '0;
		shi = 1'b1;
		slo = 1'b1;
		t_width();
		t_decode();
		t_types();
		t_wait();
		t_refresh();
		t_arb();
		end_of_test();
	end
endmodule : external_area_decoder_tb
